// ---- rpl_board.sv ----
`timescale 1ns/10ps
// Board side: open-drain reset line with a pull-up, and a keypad on the wake lines.
module rpl_board (
	// Reset line
	input  wire logic       reset_pin_oe,
	input  wire logic       reset_pin_out,
	input  wire logic       ext_hold_n,
	output logic            reset_pin_in,
	// Keypad
	input  wire logic [7:0] kbw_out,
	input  wire logic [7:0] kbw_oe,
	input  wire logic [7:0] key_n,
	output logic      [7:0] kbw_in
);
	// The pull-up wins only when nobody pulls low; the push button may hold the line low at any time.
	assign reset_pin_in = ((reset_pin_oe && !reset_pin_out) || !ext_hold_n) ? 1'b0 : 1'b1;
	// A pressed key shorts its line to ground, so a driven high line still reads low under a key.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			kbw_in[i] = kbw_oe[i] ? (kbw_out[i] & key_n[i]) : key_n[i];
		end
	end
endmodule // rpl_board

// ---- rpl_pkg.sv ----
// How it works
// R1 - Low reset pin level requests controller reset.
// R2 - Drive reset pin low on internal resets.
// R3 - Interrupt pin: falling edge, optionally plus level.
// R4 - Eight wake lines share the interrupt request.
// R5 - Wake lines always trigger on falling edges.
// R6 - General port lines reset to inputs.
// R7 - Shared port lines reset to inputs.
// R8 - Wake lines reset to inputs, software direction.
// R9 - Shared port routes serial, pulse, timer functions.
// R10 - Converter disabled at reset, digital inputs usable.
// R11 - Selected analog line reads zero while converting.
// R12 - Two-stage synchroniser before interrupt detection.
package rpl_pkg;
	localparam int GEN_W  = 7;
	localparam int SHR_W  = 8;
	localparam int KBW_W  = 8;
	localparam int ANA_W  = 5;
	localparam int SEL_W  = 3;
	// Shared port bit positions.
	localparam int SHR_SER_LO = 0;
	localparam int SHR_SER_N  = 4;
	localparam int SHR_PWM1   = 4;
	localparam int SHR_PWM2   = 5;
	localparam int SHR_TIMER_COMPARE_OUTPUT   = 6;
	localparam int SHR_TIMER_CAPTURE_INPUT   = 7;
	// Values after reset.
	localparam logic [GEN_W-1:0] GEN_DIR_RST = 7'h00;
	localparam logic [SHR_W-1:0] SHR_DIR_RST = 8'h00;
	localparam logic [KBW_W-1:0] KBW_DIR_RST = 8'h00;
	localparam logic [GEN_W-1:0] GEN_DAT_RST = 7'h00;
	localparam logic [SHR_W-1:0] SHR_DAT_RST = 8'h00;
	localparam logic [KBW_W-1:0] KBW_DAT_RST = 8'h00;
	// Length of the reset pin drive after an internal reset event, in cycles.
	localparam int RST_DRIVE_CYC = 4;
	localparam int RST_CNT_W     = 3;
endpackage

// ---- rpl_sync.sv ----
`timescale 1ns/10ps
// Two-stage synchroniser for a bus of asynchronous lines.
module rpl_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] INI = '1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// Lines
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_nxt;

	// Only the second stage is read outside.
	always_comb begin
		s1_nxt = ce ? d : s1_r;
		s2_nxt = ce ? s1_r : s2_r;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= INI;
			s2_r <= INI;
		end else begin
			s1_r <= s1_nxt; // R12
			s2_r <= s2_nxt; // R12
		end
	end

	assign q = s2_r;
endmodule // rpl_sync

// ---- rpl_top.sv ----
`timescale 1ns/10ps
// Pin logic: reset pin, interrupt request, three ports and analog-shared inputs.
module rpl_top #(
	parameter bit IRQ_LEVEL_EN = 1'b0
) (
	// Clock, enable and system reset
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          ce,
	// Reset pin (open drain) and internal reset sources
	input  wire logic                          reset_pin_in,
	output logic                               reset_pin_out,
	output logic                               reset_pin_oe,
	input  wire logic                          rst_watchdog_timer,
	input  wire logic                          rst_power_on,
	input  wire logic                          rst_illegal_addr,
	input  wire logic                          rst_stop_disabled,
	input  wire logic                          rst_low_voltage,
	output logic                               ext_reset_req,
	// Interrupt
	input  wire logic                          irq_pin_n,
	input  wire logic                          irq_enable,
	input  wire logic                          irq_ack,
	output logic                               irq_req,
	// General port
	input  wire logic [rpl_pkg::GEN_W-1:0]     general_port_lines_in,
	output logic      [rpl_pkg::GEN_W-1:0]     general_port_lines_out,
	output logic      [rpl_pkg::GEN_W-1:0]     general_port_lines_oe,
	input  wire logic [rpl_pkg::GEN_W-1:0]     gen_dir_wdata,
	input  wire logic                          gen_dir_we,
	input  wire logic [rpl_pkg::GEN_W-1:0]     gen_dat_wdata,
	input  wire logic                          gen_dat_we,
	output logic      [rpl_pkg::GEN_W-1:0]     gen_rdata,
	// Shared port and peripheral functions
	input  wire logic [rpl_pkg::SHR_W-1:0]     shared_port_in,
	output logic      [rpl_pkg::SHR_W-1:0]     shared_port_out,
	output logic      [rpl_pkg::SHR_W-1:0]     shared_port_oe,
	input  wire logic [rpl_pkg::SHR_W-1:0]     shr_dir_wdata,
	input  wire logic                          shr_dir_we,
	input  wire logic [rpl_pkg::SHR_W-1:0]     shr_dat_wdata,
	input  wire logic                          shr_dat_we,
	output logic      [rpl_pkg::SHR_W-1:0]     shr_rdata,
	input  wire logic                          serial_en,
	input  wire logic [rpl_pkg::SHR_SER_N-1:0] shared_port_serial_lines_out,
	input  wire logic [rpl_pkg::SHR_SER_N-1:0] shared_port_serial_lines_oe,
	output logic      [rpl_pkg::SHR_SER_N-1:0] shared_port_serial_lines_in,
	input  wire logic                          pulse_first_en,
	input  wire logic                          pulse_output_first,
	input  wire logic                          pulse_second_en,
	input  wire logic                          pulse_output_second,
	input  wire logic                          compare_en,
	input  wire logic                          timer_compare_output,
	output logic                               timer_capture_input,
	// Keyboard-wake port
	input  wire logic [rpl_pkg::KBW_W-1:0]     keyboard_wake_lines_in,
	output logic      [rpl_pkg::KBW_W-1:0]     keyboard_wake_lines_out,
	output logic      [rpl_pkg::KBW_W-1:0]     keyboard_wake_lines_oe,
	input  wire logic [rpl_pkg::KBW_W-1:0]     kbw_dir_wdata,
	input  wire logic                          kbw_dir_we,
	input  wire logic [rpl_pkg::KBW_W-1:0]     kbw_dat_wdata,
	input  wire logic                          kbw_dat_we,
	output logic      [rpl_pkg::KBW_W-1:0]     kbw_rdata,
	// Analog-shared inputs
	input  wire logic [rpl_pkg::ANA_W-1:0]     analog_shared_inputs,
	input  wire logic                          adc_en_wdata,
	input  wire logic                          adc_en_we,
	input  wire logic [rpl_pkg::SEL_W-1:0]     adc_sel_wdata,
	output logic                               adc_en,
	output logic      [rpl_pkg::ANA_W-1:0]     ana_rdata
);
	// Port state.
	logic [rpl_pkg::GEN_W-1:0] gen_dir_r, gen_dir_nxt, gen_dat_r, gen_dat_nxt;
	logic [rpl_pkg::SHR_W-1:0] shr_dir_r, shr_dir_nxt, shr_dat_r, shr_dat_nxt;
	logic [rpl_pkg::KBW_W-1:0] kbw_dir_r, kbw_dir_nxt, kbw_dat_r, kbw_dat_nxt;
	logic                      adc_en_r, adc_en_nxt;
	logic [rpl_pkg::SEL_W-1:0] adc_sel_r, adc_sel_nxt;
	// Interrupt and reset-pin state.
	logic                      irq_q_r, irq_q_nxt;
	logic                      irq_pin_s, irq_prev_r, irq_prev_nxt;
	logic [rpl_pkg::KBW_W-1:0] kbw_s, kbw_prev_r, kbw_prev_nxt;
	logic                      irq_event;
	logic                      int_rst;
	logic [rpl_pkg::RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;

	// Interrupt and wake lines are synchronised before any edge logic sees them.
	rpl_sync #(.W(1), .INI(1'b1)) u_sync_irq (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.d      (irq_pin_n),
		.q      (irq_pin_s)
	); // R12
	rpl_sync #(.W(rpl_pkg::KBW_W), .INI(8'hff)) u_sync_kbw (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.d      (keyboard_wake_lines_in),
		.q      (kbw_s)
	); // R12

	// Port registers; directions come out of reset as inputs.
	always_comb begin
		gen_dir_nxt = (ce && gen_dir_we) ? gen_dir_wdata : gen_dir_r;
		gen_dat_nxt = (ce && gen_dat_we) ? gen_dat_wdata : gen_dat_r;
		shr_dir_nxt = (ce && shr_dir_we) ? shr_dir_wdata : shr_dir_r;
		shr_dat_nxt = (ce && shr_dat_we) ? shr_dat_wdata : shr_dat_r;
		kbw_dir_nxt = (ce && kbw_dir_we) ? kbw_dir_wdata : kbw_dir_r;
		kbw_dat_nxt = (ce && kbw_dat_we) ? kbw_dat_wdata : kbw_dat_r;
		adc_en_nxt  = (ce && adc_en_we) ? adc_en_wdata : adc_en_r;
		adc_sel_nxt = (ce && adc_en_we) ? adc_sel_wdata : adc_sel_r;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gen_dir_r <= rpl_pkg::GEN_DIR_RST; // R6
			shr_dir_r <= rpl_pkg::SHR_DIR_RST; // R7
			kbw_dir_r <= rpl_pkg::KBW_DIR_RST; // R8
			gen_dat_r <= rpl_pkg::GEN_DAT_RST;
			shr_dat_r <= rpl_pkg::SHR_DAT_RST;
			kbw_dat_r <= rpl_pkg::KBW_DAT_RST;
			adc_en_r  <= 1'b0; // R10
			adc_sel_r <= 3'h0;
		end else begin
			gen_dir_r <= gen_dir_nxt;
			shr_dir_r <= shr_dir_nxt;
			kbw_dir_r <= kbw_dir_nxt; // R8
			gen_dat_r <= gen_dat_nxt;
			shr_dat_r <= shr_dat_nxt;
			kbw_dat_r <= kbw_dat_nxt;
			adc_en_r  <= adc_en_nxt;
			adc_sel_r <= adc_sel_nxt;
		end
	end

	// Plain ports drive their data latch where the direction bit says output.
	assign general_port_lines_out  = gen_dat_r;
	assign general_port_lines_oe   = gen_dir_r;
	assign gen_rdata               = general_port_lines_in;
	assign keyboard_wake_lines_out = kbw_dat_r;
	assign keyboard_wake_lines_oe  = kbw_dir_r;
	assign kbw_rdata               = keyboard_wake_lines_in;

	// Shared port: an enabled peripheral owns its line, otherwise software does.
	always_comb begin
		shared_port_out = shr_dat_r;
		shared_port_oe  = shr_dir_r;
		if (serial_en) begin
			shared_port_out[rpl_pkg::SHR_SER_LO +: rpl_pkg::SHR_SER_N] = shared_port_serial_lines_out; // R9
			shared_port_oe[rpl_pkg::SHR_SER_LO +: rpl_pkg::SHR_SER_N]  = shared_port_serial_lines_oe; // R9
		end
		if (pulse_first_en) begin
			shared_port_out[rpl_pkg::SHR_PWM1] = pulse_output_first; // R9
			shared_port_oe[rpl_pkg::SHR_PWM1]  = 1'b1;
		end
		if (pulse_second_en) begin
			shared_port_out[rpl_pkg::SHR_PWM2] = pulse_output_second; // R9
			shared_port_oe[rpl_pkg::SHR_PWM2]  = 1'b1;
		end
		if (compare_en) begin
			shared_port_out[rpl_pkg::SHR_TIMER_COMPARE_OUTPUT] = timer_compare_output; // R9
			shared_port_oe[rpl_pkg::SHR_TIMER_COMPARE_OUTPUT]  = 1'b1;
		end
	end
	assign shared_port_serial_lines_in = shared_port_in[rpl_pkg::SHR_SER_LO +: rpl_pkg::SHR_SER_N]; // R9
	assign timer_capture_input         = shared_port_in[rpl_pkg::SHR_TIMER_CAPTURE_INPUT]; // R9
	assign shr_rdata                   = shared_port_in;

	// Analog-shared digital reads; the converting line reads zero.
	always_comb begin
		ana_rdata = analog_shared_inputs; // R10
		if (adc_en_r && (32'(adc_sel_r) < rpl_pkg::ANA_W)) begin
			ana_rdata[adc_sel_r] = 1'b0; // R11
		end
	end
	assign adc_en = adc_en_r;

	// Interrupt detection. Wake lines are edge-only even when the pin is level-sensitive.
	always_comb begin
		irq_event = irq_prev_r & ~irq_pin_s; // R3
		if (IRQ_LEVEL_EN) begin
			irq_event = ~irq_pin_s; // R3
		end
		irq_event    = irq_event | (|(kbw_prev_r & ~kbw_s)); // R4 R5
		irq_event    = irq_event & irq_enable; // R4
		irq_prev_nxt = ce ? irq_pin_s : irq_prev_r;
		kbw_prev_nxt = ce ? kbw_s : kbw_prev_r;
		// A new event in the acknowledge cycle wins over the clear.
		irq_q_nxt    = irq_q_r;
		if (ce) begin
			irq_q_nxt = irq_event | (irq_q_r & ~irq_ack);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_prev_r <= 1'b1;
			kbw_prev_r <= 8'hff;
			irq_q_r    <= 1'b0;
		end else begin
			irq_prev_r <= irq_prev_nxt;
			kbw_prev_r <= kbw_prev_nxt;
			irq_q_r    <= irq_q_nxt;
		end
	end
	assign irq_req = irq_q_r;

	// Internal reset sources pull the pin low; a stretch keeps short pulses visible.
	assign int_rst = rst_watchdog_timer | rst_power_on | rst_illegal_addr
		| rst_stop_disabled | rst_low_voltage;
	always_comb begin
		rst_cnt_nxt = rst_cnt_r;
		if (ce && int_rst) begin
			rst_cnt_nxt = rpl_pkg::RST_CNT_W'(rpl_pkg::RST_DRIVE_CYC); // R2
		end else if (ce && rst_cnt_r != '0) begin
			rst_cnt_nxt = rst_cnt_r - 3'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_cnt_r <= rpl_pkg::RST_CNT_W'(rpl_pkg::RST_DRIVE_CYC);
		end else begin
			rst_cnt_r <= rst_cnt_nxt;
		end
	end

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe  = int_rst | (rst_cnt_r != '0) | ~resetn; // R2
	assign ext_reset_req = ~reset_pin_in; // R1

	// Assertions.
	sequence s_irq_fall;
		irq_enable && ce && $fell(irq_pin_s);
	endsequence
	property p_irq_edge;
		@(posedge clk) disable iff (!resetn) s_irq_fall |=> irq_req;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("pin fall missed"); // R3
	property p_kbw_edge;
		@(posedge clk) disable iff (!resetn)
			(irq_enable && ce && |(kbw_prev_r & ~kbw_s)) |=> irq_req;
	endproperty
	a_kbw_edge: assert property (p_kbw_edge) else $error("wake fall missed"); // R4
	property p_kbw_lvl;
		@(posedge clk) disable iff (!resetn)
			(!IRQ_LEVEL_EN && irq_ack && ce && irq_pin_s && kbw_s == kbw_prev_r && irq_prev_r) |=> !irq_req;
	endproperty
	a_kbw_lvl: assert property (p_kbw_lvl) else $error("low level set irq"); // R5
	property p_rst_drive;
		@(posedge clk) disable iff (!resetn) (ce && int_rst) |=> reset_pin_oe && !reset_pin_out;
	endproperty
	a_rst_drive: assert property (p_rst_drive) else $error("reset pin not driven"); // R2
	property p_rst_req;
		@(posedge clk) !reset_pin_in |-> ext_reset_req;
	endproperty
	a_rst_req: assert property (p_rst_req) else $error("reset request lost"); // R1
	property p_ana_zero;
		@(posedge clk) disable iff (!resetn) (adc_en_r && adc_sel_r < 3'h5) |-> !ana_rdata[adc_sel_r];
	endproperty
	a_ana_zero: assert property (p_ana_zero) else $error("selected line not zero"); // R11
	property p_dir_rst;
		@(posedge clk) $rose(resetn) |-> (gen_dir_r == '0 && shr_dir_r == '0 && kbw_dir_r == '0 && !adc_en_r);
	endproperty
	a_dir_rst: assert property (p_dir_rst) else $error("not inputs at reset"); // R6
	property p_timer_capture_input;
		@(posedge clk) disable iff (!resetn) timer_capture_input == shared_port_in[rpl_pkg::SHR_TIMER_CAPTURE_INPUT];
	endproperty
	a_timer_capture_input: assert property (p_timer_capture_input) else $error("capture route wrong"); // R9
endmodule // rpl_top

// ---- rpl_top_test.sv ----
`timescale 1ns/10ps
module rpl_top_test;
	// Design-facing signals, named as the ports they feed.
	logic clk, resetn, ce, reset_pin_in, reset_pin_out, reset_pin_oe, ext_reset_req, ext_hold_n;
	logic [4:0] rsrc, analog_shared_inputs, ana_rdata;
	logic irq_pin_n, irq_enable, irq_ack, irq_req, adc_en_wdata, adc_en_we, adc_en;
	logic [6:0] general_port_lines_in, general_port_lines_out, general_port_lines_oe;
	logic [6:0] gen_dir_wdata, gen_dat_wdata, gen_rdata;
	logic gen_dir_we, gen_dat_we, shr_dir_we, shr_dat_we, kbw_dir_we, kbw_dat_we;
	logic [7:0] shared_port_in, shared_port_out, shared_port_oe, shr_dir_wdata, shr_dat_wdata, shr_rdata;
	logic [7:0] keyboard_wake_lines_in, keyboard_wake_lines_out, keyboard_wake_lines_oe, key_n;
	logic [7:0] kbw_dir_wdata, kbw_dat_wdata, kbw_rdata;
	logic serial_en, pulse_first_en, pulse_output_first, pulse_second_en, pulse_output_second;
	logic compare_en, timer_compare_output, timer_capture_input;
	logic [3:0] shared_port_serial_lines_out, shared_port_serial_lines_oe, shared_port_serial_lines_in;
	logic [2:0] adc_sel_wdata;
	logic irq_req_lvl;
	int err_count, n_checks, n;

	rpl_top #(.IRQ_LEVEL_EN(1'b0)) i_rpl_top (.clk, .resetn, .ce, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
		.rst_watchdog_timer(rsrc[0]), .rst_power_on(rsrc[1]), .rst_illegal_addr(rsrc[2]),
		.rst_stop_disabled(rsrc[3]), .rst_low_voltage(rsrc[4]), .ext_reset_req, .irq_pin_n, .irq_enable,
		.irq_ack, .irq_req, .general_port_lines_in, .general_port_lines_out, .general_port_lines_oe,
		.gen_dir_wdata, .gen_dir_we, .gen_dat_wdata, .gen_dat_we, .gen_rdata, .shared_port_in, .shared_port_out,
		.shared_port_oe, .shr_dir_wdata, .shr_dir_we, .shr_dat_wdata, .shr_dat_we, .shr_rdata, .serial_en,
		.shared_port_serial_lines_out, .shared_port_serial_lines_oe, .shared_port_serial_lines_in,
		.pulse_first_en, .pulse_output_first, .pulse_second_en, .pulse_output_second, .compare_en,
		.timer_compare_output, .timer_capture_input, .keyboard_wake_lines_in, .keyboard_wake_lines_out,
		.keyboard_wake_lines_oe, .kbw_dir_wdata, .kbw_dir_we, .kbw_dat_wdata, .kbw_dat_we, .kbw_rdata,
		.analog_shared_inputs, .adc_en_wdata, .adc_en_we, .adc_sel_wdata, .adc_en, .ana_rdata);
	// Second copy built with the level option; it shares every input and only its request is watched.
	rpl_top #(.IRQ_LEVEL_EN(1'b1)) i_rpl_top_lvl (.clk, .resetn, .ce, .reset_pin_in, .reset_pin_out(),
		.reset_pin_oe(), .rst_watchdog_timer(rsrc[0]), .rst_power_on(rsrc[1]), .rst_illegal_addr(rsrc[2]),
		.rst_stop_disabled(rsrc[3]), .rst_low_voltage(rsrc[4]), .ext_reset_req(), .irq_pin_n, .irq_enable,
		.irq_ack, .irq_req(irq_req_lvl), .general_port_lines_in, .general_port_lines_out(),
		.general_port_lines_oe(), .gen_dir_wdata, .gen_dir_we, .gen_dat_wdata, .gen_dat_we, .gen_rdata(),
		.shared_port_in, .shared_port_out(), .shared_port_oe(), .shr_dir_wdata, .shr_dir_we, .shr_dat_wdata,
		.shr_dat_we, .shr_rdata(), .serial_en, .shared_port_serial_lines_out, .shared_port_serial_lines_oe,
		.shared_port_serial_lines_in(), .pulse_first_en, .pulse_output_first, .pulse_second_en,
		.pulse_output_second, .compare_en, .timer_compare_output, .timer_capture_input(),
		.keyboard_wake_lines_in, .keyboard_wake_lines_out(), .keyboard_wake_lines_oe(), .kbw_dir_wdata,
		.kbw_dir_we, .kbw_dat_wdata, .kbw_dat_we, .kbw_rdata(), .analog_shared_inputs, .adc_en_wdata,
		.adc_en_we, .adc_sel_wdata, .adc_en(), .ana_rdata());
	rpl_board i_rpl_board (.reset_pin_oe, .reset_pin_out, .ext_hold_n, .reset_pin_in,
		.kbw_out(keyboard_wake_lines_out), .kbw_oe(keyboard_wake_lines_oe), .key_n, .kbw_in(keyboard_wake_lines_in));

	// Free-running 25 MHz clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Compare one value and count the outcome.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Let edges pass, then sample once their updates have landed.
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic results;
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Bounded wait for the request; the synchroniser makes it neither instant nor slow.
	task automatic wait_irq;
		n = 0;
		while (irq_req !== 1'b1 && n < 8) begin
			tick(1);
			n++;
		end
		chk(n >= 2 && n <= 4, 1);
		if (n == 8)
			results();
	endtask
	// Acknowledge while the source stays low: only a new falling edge may raise it again.
	task automatic ack_idle;
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		tick(6);
		chk(irq_req, 0);
	endtask
	task automatic chk_inputs;
		chk(general_port_lines_oe, 0);
		chk(shared_port_oe, 0);
		chk(keyboard_wake_lines_oe, 0);
		chk(adc_en, 0);
		chk(ana_rdata, analog_shared_inputs);
	endtask

	// Main sequence.
	initial begin
		ce = 1'b1;
		resetn = 1'b0;
		ext_hold_n = 1'b1;
		rsrc = '0;
		{irq_pin_n, irq_enable, irq_ack, key_n} = {1'b1, 1'b0, 1'b0, 8'hff};
		{gen_dir_we, gen_dat_we, shr_dir_we, shr_dat_we, kbw_dir_we, kbw_dat_we, adc_en_we, adc_en_wdata} = '0;
		{gen_dir_wdata, gen_dat_wdata, shr_dir_wdata, shr_dat_wdata, kbw_dir_wdata, kbw_dat_wdata, adc_sel_wdata} = '0;
		{serial_en, pulse_first_en, pulse_output_first, pulse_second_en, pulse_output_second} = '0;
		{compare_en, timer_compare_output, shared_port_serial_lines_out, shared_port_serial_lines_oe} = '0;
		general_port_lines_in = $urandom(61);
		shared_port_in = $urandom;
		analog_shared_inputs = $urandom;
		err_count = 0;
		n_checks = 0;
		tick(10);
		chk(reset_pin_oe, 1);
		chk_inputs();
		@(posedge clk);
		resetn <= 1'b1;
		tick(1);
		chk({reset_pin_oe, ext_reset_req}, 2'h3);
		tick(6);
		chk({reset_pin_oe, ext_reset_req}, 2'h0);
		// Every internal source pulls the pin, and the pull outlasts the source.
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			rsrc <= 5'h01 << i;
			tick(1);
			chk({reset_pin_oe, reset_pin_in}, 2'h2);
			@(posedge clk);
			rsrc <= '0;
			tick(1);
			chk(reset_pin_oe, 1);
			tick(6);
			chk({reset_pin_oe, reset_pin_in}, 2'h1);
		end
		@(posedge clk);
		ext_hold_n <= 1'b0;
		tick(1);
		chk({ext_reset_req, reset_pin_oe}, 2'h2);
		@(posedge clk);
		ext_hold_n <= 1'b1;
		irq_enable <= 1'b1;
		tick(1);
		chk(ext_reset_req, 0);
		@(posedge clk);
		irq_pin_n <= 1'b0;
		wait_irq();
		ack_idle();
		chk(irq_req_lvl, 1);
		@(posedge clk);
		irq_pin_n <= 1'b1;
		tick(4);
		// Each wake line alone raises the shared request.
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			key_n <= ~(8'h01 << k);
			wait_irq();
			ack_idle();
			chk(irq_req_lvl, 0);
			@(posedge clk);
			key_n <= 8'hff;
			tick(4);
		end
		@(posedge clk);
		irq_enable <= 1'b0;
		irq_pin_n <= 1'b0;
		key_n <= 8'h00;
		tick(6);
		chk(irq_req, 0);
		chk(irq_req_lvl, 0);
		@(posedge clk);
		irq_pin_n <= 1'b1;
		key_n <= 8'hff;
		// Random direction and data writes on all three ports at once.
		for (int r = 0; r < 20; r++) begin
			@(posedge clk);
			{gen_dir_wdata, gen_dat_wdata, shr_dir_wdata} <= {$urandom, $urandom};
			{shr_dat_wdata, kbw_dir_wdata, kbw_dat_wdata} <= $urandom;
			{general_port_lines_in, shared_port_in} <= $urandom;
			{gen_dir_we, gen_dat_we, shr_dir_we, shr_dat_we, kbw_dir_we, kbw_dat_we} <= '1;
			@(posedge clk);
			{gen_dir_we, gen_dat_we, shr_dir_we, shr_dat_we, kbw_dir_we, kbw_dat_we} <= '0;
			#1;
			chk(general_port_lines_oe, gen_dir_wdata);
			chk(general_port_lines_out & gen_dir_wdata, gen_dat_wdata & gen_dir_wdata);
			chk(gen_rdata, general_port_lines_in);
			chk(shared_port_oe, shr_dir_wdata);
			chk(shared_port_out & shr_dir_wdata, shr_dat_wdata & shr_dir_wdata);
			chk(shr_rdata, shared_port_in);
			chk(keyboard_wake_lines_oe, kbw_dir_wdata);
			chk(kbw_rdata, (kbw_dir_wdata & kbw_dat_wdata) | ~kbw_dir_wdata);
		end
		// A second reset in mid-run returns every line to input.
		@(posedge clk);
		resetn <= 1'b0;
		tick(2);
		chk_inputs();
		@(posedge clk);
		resetn <= 1'b1;
		tick(6);
		// Peripheral functions take over the shared lines.
		for (int r = 0; r < 8; r++) begin
			@(posedge clk);
			{serial_en, pulse_first_en, pulse_second_en, compare_en} <= 4'hf;
			{shared_port_serial_lines_out, shared_port_serial_lines_oe} <= $urandom;
			{pulse_output_first, pulse_output_second, timer_compare_output} <= $urandom;
			shared_port_in <= $urandom;
			tick(1);
			chk(shared_port_oe[3:0], shared_port_serial_lines_oe);
			chk(shared_port_out[3:0] & shared_port_serial_lines_oe,
				shared_port_serial_lines_out & shared_port_serial_lines_oe);
			chk(shared_port_serial_lines_in, shared_port_in[3:0]);
			chk(shared_port_out[6:4], {timer_compare_output, pulse_output_second, pulse_output_first});
			chk(shared_port_oe[6:4], 3'h7);
			chk(timer_capture_input, shared_port_in[7]);
		end
		// Every channel select, including the codes past the last line.
		for (int s = 0; s < 8; s++) begin
			@(posedge clk);
			{adc_en_we, adc_en_wdata, adc_sel_wdata} <= {2'h3, s[2:0]};
			analog_shared_inputs <= $urandom;
			@(posedge clk);
			adc_en_we <= 1'b0;
			#1;
			chk(adc_en, 1);
			chk(ana_rdata, analog_shared_inputs & ~(8'h01 << s));
		end
		@(posedge clk);
		{adc_en_we, adc_en_wdata} <= 2'h2;
		@(posedge clk);
		adc_en_we <= 1'b0;
		#1;
		chk(ana_rdata, analog_shared_inputs);
		results();
	end

	// Cut a hang short.
	initial begin
		#2000000;
		err_count++;
		results();
	end
endmodule // rpl_top_test
